// [src/csis_arbiter.sv]
// Fixed priority picker: lowest set index wins.
// Assumes requests are already gated by their enables.
`timescale 1ns/1ps
`default_nettype none

module csis_arbiter #(
	parameter int NSRC = 8
) (
	input  wire logic [NSRC-1:0]         req,
	output logic                         any,
	output logic [$clog2(NSRC)-1:0]      idx
);

	initial begin
		if (NSRC < 2 || NSRC > 64) $error("csis_arbiter: NSRC out of range");
	end

	// Scan downward so the lowest index is left standing
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = i[$clog2(NSRC)-1:0];
			end
		end
	end

endmodule

`default_nettype wire

// [src/csis_core.sv]
// Core state and interrupt sequencer: flags, register file, stack pointer and interrupt entry/return.
// Assumes execution drives one-cycle strobes on the same clock; interrupt requests are synchronous.
`include "csis_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Function
// - Sign flag is negative xor overflow
// - Bit five reports low-nibble carry
// - Bit three holds signed overflow flag
// - Negative bit two, zero one, carry zero
// - Byte and word operand/result register ports
// - Registers sit at data addresses 0x00-0x1F
// - Pairs 26/27, 28/29, 30/31 form pointers
// - Stack grows downward, pointer marks top
// - Byte push decrements, pop increments by one
// - Calls and entry minus two, returns plus two
// - Stack pointer bytes at 0x3E and 0x3D
// - Stack pointer resets to last SRAM address; code loads CSIS_RST_SP and ignores LAST_SRAM
// - ALU result written back in one cycle
// - Accept only with source and global enable
// - Lowest vector wins simultaneous requests
// - Select bit moves vectors to boot start
// - Entry clears global enable, return sets it
// - Vectoring or writing one clears flag
// - Disabled flags stay pending until serviced
// - Level sources request only while present
// - One instruction runs after return first
// - Flag register never saved or restored
// - Clear-enable blocks same-cycle interrupts
// - Global enable is flag register bit seven
// - One instruction runs after set-enable
// - Entry takes four cycles, wake adds four
// - Return takes four cycles, pops two bytes
module csis_core
	import csis_pkg::*;
#(
	parameter int                 NSRC      = 8,
	parameter logic [15:0]        LAST_SRAM = `CSIS_RST_SP,
	parameter logic [15:0]        BOOT_BASE = 16'h0c00,
	parameter logic [NSRC-1:0]    LEVEL_SRC = '0
) (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic                   clk_en,
	// I/O register port
	input  wire logic                   io_wr,
	input  wire logic                   io_rd,
	input  wire logic [5:0]             io_addr,
	input  wire logic [7:0]             io_wdata,
	output logic      [7:0]             io_rdata_q,
	// Register file port
	input  wire logic [4:0]             rf_a_addr,
	input  wire logic [4:0]             rf_b_addr,
	input  wire logic                   rf_rd_wide,
	output logic      [15:0]            rf_a_data_q,
	output logic      [7:0]             rf_b_data_q,
	input  wire logic                   rf_wr,
	input  wire logic                   rf_wr_wide,
	input  wire logic [4:0]             rf_wr_addr,
	input  wire logic [15:0]            rf_wr_data,
	// ALU flag results
	input  wire csis_pkg::csis_flop_e   fl_op,
	input  wire logic                   fl_c,
	input  wire logic                   fl_h,
	input  wire logic                   fl_v,
	input  wire logic [7:0]             fl_res,
	input  wire logic                   fl_t_wr,
	input  wire logic                   fl_t,
	// Instruction events
	input  wire logic                   instr_done,
	input  wire logic                   instr_sei,
	input  wire logic                   instr_cli,
	input  wire logic                   instr_return_from_interrupt,
	input  wire logic                   asleep,
	input  wire csis_pkg::csis_spop_e   sp_op,
	// Interrupt sources
	input  wire logic [NSRC-1:0]        irq_event,
	input  wire logic [NSRC-1:0]        irq_enable,
	input  wire logic [NSRC-1:0]        irq_flag_clr,
	input  wire logic                   boot_reset_fuse,
	// Outputs to execution
	output logic      [7:0]             core_flags_q,
	output logic      [15:0]            sp_q,
	output logic      [NSRC-1:0]        irq_pending_q,
	output logic                        irq_take_q,
	output logic                        seq_busy_q,
	output logic      [15:0]            vector_q,
	output logic      [15:0]            reset_vector_q
);

	localparam int IW = $clog2(NSRC);

	initial begin
		if (NSRC < 2 || NSRC > 64) $error("csis_core: NSRC out of range");
	end

	logic              rst_m_q;
	logic              rst_n_q;
	logic [7:0]        ctrl_q;
	logic [2:0]        cnt_q;
	logic              hold_q;
	csis_state_e       state_q;
	logic              arb_any;
	logic [IW-1:0]     arb_idx;
	logic [NSRC-1:0]   gated;
	logic [IW-1:0]     take_idx_q;
	logic [15:0]       rf_a_raw;
	logic [7:0]        rf_b_raw;

	// Reset release through two flops
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// Stack pointer step for an operation
	function automatic logic [15:0] sp_next(input logic [15:0] sp, input csis_spop_e op);
		case (op)
			CSIS_SP_PUSH: sp_next = sp - 16'h0001;
			CSIS_SP_POP:  sp_next = sp + 16'h0001;
			CSIS_SP_CALL: sp_next = sp - 16'h0002;
			CSIS_SP_RET:  sp_next = sp + 16'h0002;
			default:      sp_next = sp;
		endcase
	endfunction

	// Register file, addressed by data-space index 0x00..0x1F
	csis_regfile #(
		.NREG (32)
	) u_rf (
		.clock     (clock),
		.clk_en    (clk_en),
		.rd_a_addr (rf_a_addr),
		.rd_b_addr (rf_b_addr),
		.rd_wide   (rf_rd_wide),
		.rd_a_data (rf_a_raw),
		.rd_b_data (rf_b_raw),
		.wr_en     (rf_wr),
		.wr_wide   (rf_wr_wide),
		.wr_addr   (rf_wr_addr),
		.wr_data   (rf_wr_data)
	);

	// Outputs must come from flops: the file already registers, so pass as a flop copy
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rf_a_data_q <= 16'h0000;
			rf_b_data_q <= 8'h00;
		end else if (clk_en) begin
			rf_a_data_q <= rf_a_raw;
			rf_b_data_q <= rf_b_raw;
		end
	end

	// Pending flags: set beats clear; hardware clears on vectoring
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irq_pending_q <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < NSRC; i++) begin
				if (LEVEL_SRC[i]) begin
					irq_pending_q[i] <= irq_event[i];
				end else if (irq_event[i]) begin
					irq_pending_q[i] <= 1'b1;
				end else if (irq_flag_clr[i]) begin
					irq_pending_q[i] <= 1'b0;
				end else if (irq_take_q && take_idx_q == IW'(i)) begin // Latched index: arbiter output drops with enable
					irq_pending_q[i] <= 1'b0;
				end
			end
		end
	end

	// Per-source and global gating; cli in this cycle blocks at once
	always_comb begin
		gated = irq_pending_q & irq_enable;
		if (!core_flags_q[`CSIS_BIT_I] || instr_cli) begin
			gated = '0;
		end
	end

	csis_arbiter #(
		.NSRC (NSRC)
	) u_arb (
		.req (gated),
		.any (arb_any),
		.idx (arb_idx)
	);

	// Hold off one instruction after sei and after the return
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			hold_q <= 1'b0;
		end else if (clk_en) begin
			if (instr_sei && !core_flags_q[`CSIS_BIT_I]) begin
				hold_q <= 1'b1;
			end else if (state_q == CSIS_ST_RETURN_FROM_INTERRUPT && cnt_q == 3'h1) begin
				hold_q <= 1'b1;
			end else if (instr_done) begin
				hold_q <= 1'b0;
			end
		end
	end

	// Sequencer: entry waits for the instruction boundary
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q    <= CSIS_ST_RUN;
			cnt_q      <= 3'h0;
			irq_take_q <= 1'b0;
			seq_busy_q <= 1'b0;
			vector_q   <= 16'h0000;
			take_idx_q <= '0;
		end else if (clk_en) begin
			irq_take_q <= 1'b0;
			case (state_q)
				CSIS_ST_RUN: begin
					if (instr_return_from_interrupt) begin
						state_q    <= CSIS_ST_RETURN_FROM_INTERRUPT;
						cnt_q      <= `CSIS_RETURN_FROM_INTERRUPT_CYCLES;
						seq_busy_q <= 1'b1;
					end else if (arb_any && instr_done && !hold_q) begin
						vector_q   <= (ctrl_q[`CSIS_BIT_VSEL] ? BOOT_BASE : 16'h0000)
							+ {{(15 - IW){1'b0}}, arb_idx, 1'b0} + 16'h0002;
						irq_take_q <= 1'b1;
						take_idx_q <= arb_idx;
						seq_busy_q <= 1'b1;
						if (asleep) begin
							state_q <= CSIS_ST_WAKE;
							cnt_q   <= `CSIS_WAKE_CYCLES;
						end else begin
							state_q <= CSIS_ST_ENTRY;
							cnt_q   <= `CSIS_ENTRY_CYCLES;
						end
					end
				end
				CSIS_ST_WAKE: begin
					cnt_q <= cnt_q - 3'h1;
					if (cnt_q == 3'h1) begin
						state_q <= CSIS_ST_ENTRY;
						cnt_q   <= `CSIS_ENTRY_CYCLES;
					end
				end
				CSIS_ST_ENTRY, CSIS_ST_RETURN_FROM_INTERRUPT: begin
					cnt_q <= cnt_q - 3'h1;
					if (cnt_q == 3'h1) begin
						state_q    <= CSIS_ST_RUN;
						seq_busy_q <= 1'b0;
					end
				end
				default: begin
					state_q <= CSIS_ST_RUN;
				end
			endcase
		end
	end

	// Flag register; entry and return never save or restore it
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			core_flags_q <= `CSIS_RST_FLAGS;
		end else if (clk_en) begin
			if (io_wr && io_addr == `CSIS_OFF_FLAGS) begin
				core_flags_q <= {io_wdata[7:5], io_wdata[`CSIS_BIT_N] ^ io_wdata[`CSIS_BIT_V], io_wdata[3:0]};
			end else begin
				if (fl_op != CSIS_FL_NONE) begin
					core_flags_q[`CSIS_BIT_Z] <= (fl_res == 8'h00);
					core_flags_q[`CSIS_BIT_N] <= fl_res[7];
					core_flags_q[`CSIS_BIT_C] <= fl_c;
					core_flags_q[`CSIS_BIT_V] <= (fl_op == CSIS_FL_ARITH) ? fl_v : 1'b0;
					core_flags_q[`CSIS_BIT_S] <= fl_res[7] ^ ((fl_op == CSIS_FL_ARITH) ? fl_v : 1'b0);
					if (fl_op == CSIS_FL_ARITH) begin
						core_flags_q[`CSIS_BIT_H] <= fl_h;
					end
				end
				if (fl_t_wr) begin
					core_flags_q[`CSIS_BIT_T] <= fl_t;
				end
				if (irq_take_q) begin
					core_flags_q[`CSIS_BIT_I] <= 1'b0;
				end else if (state_q == CSIS_ST_RETURN_FROM_INTERRUPT && cnt_q == 3'h1) begin
					core_flags_q[`CSIS_BIT_I] <= 1'b1;
				end else if (instr_cli) begin
					core_flags_q[`CSIS_BIT_I] <= 1'b0;
				end else if (instr_sei) begin
					core_flags_q[`CSIS_BIT_I] <= 1'b1;
				end
			end
		end
	end

	// Stack pointer: bytes written alone, moved by stack operations
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sp_q <= `CSIS_RST_SP;
		end else if (clk_en) begin
			if (io_wr && io_addr == `CSIS_OFF_SP_LOW) begin
				sp_q[7:0] <= io_wdata;
			end else if (io_wr && io_addr == `CSIS_OFF_SP_HIGH) begin
				sp_q[15:8] <= io_wdata;
			end else if (irq_take_q) begin
				sp_q <= sp_next(sp_q, CSIS_SP_CALL);
			end else if (state_q == CSIS_ST_RETURN_FROM_INTERRUPT && cnt_q == `CSIS_RETURN_FROM_INTERRUPT_CYCLES) begin
				sp_q <= sp_next(sp_q, CSIS_SP_RET);
			end else begin
				sp_q <= sp_next(sp_q, sp_op);
			end
		end
	end

	// Control register with the vector table select
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= `CSIS_RST_CTRL;
		end else if (clk_en && io_wr && io_addr == `CSIS_OFF_CORE_CTRL) begin
			ctrl_q <= {6'h00, io_wdata[`CSIS_BIT_VSEL], 1'b0};
		end
	end

	// Reset vector follows the fuse, sampled after release
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reset_vector_q <= 16'h0000;
		end else if (clk_en) begin
			reset_vector_q <= boot_reset_fuse ? BOOT_BASE : 16'h0000;
		end
	end

	// I/O read data; unmapped offsets read zero
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			io_rdata_q <= 8'h00;
		end else if (clk_en && io_rd) begin
			if (io_addr == `CSIS_OFF_SP_LOW) begin
				io_rdata_q <= sp_q[7:0];
			end else if (io_addr == `CSIS_OFF_SP_HIGH) begin
				io_rdata_q <= sp_q[15:8];
			end else if (io_addr == `CSIS_OFF_FLAGS) begin
				io_rdata_q <= core_flags_q;
			end else if (io_addr == `CSIS_OFF_CORE_CTRL) begin
				io_rdata_q <= ctrl_q;
			end else begin
				io_rdata_q <= 8'h00;
			end
		end
	end

endmodule

`default_nettype wire

// [src/csis_map.svh]
// Constants of the core state and interrupt sequencer: offsets, fields, resets, timing.
// Assumes inclusion by bare name from any file of this block.
`ifndef CSIS_MAP_SVH
`define CSIS_MAP_SVH

// I/O offsets of the stack pointer bytes, the flag register and the control register
`define CSIS_OFF_SP_LOW     6'h3d
`define CSIS_OFF_SP_HIGH    6'h3e
`define CSIS_OFF_FLAGS      6'h3f
`define CSIS_OFF_CORE_CTRL  6'h35

// Flag register bit positions
`define CSIS_BIT_C  0
`define CSIS_BIT_Z  1
`define CSIS_BIT_N  2
`define CSIS_BIT_V  3
`define CSIS_BIT_S  4
`define CSIS_BIT_H  5
`define CSIS_BIT_T  6
`define CSIS_BIT_I  7

// Control register: vector table select bit
`define CSIS_BIT_VSEL 1

// Reset values
`define CSIS_RST_FLAGS 8'h00
`define CSIS_RST_CTRL  8'h00
`define CSIS_RST_SP    16'h04ff

// Register file addresses of the pointer low bytes
`define CSIS_PTR_X 5'h1a
`define CSIS_PTR_Y 5'h1c
`define CSIS_PTR_Z 5'h1e

// Timing in clock cycles
`define CSIS_ENTRY_CYCLES  3'h4
`define CSIS_WAKE_CYCLES   3'h4
`define CSIS_RETURN_FROM_INTERRUPT_CYCLES   3'h4

`endif

// [src/csis_pkg.sv]
// Types of the core state and interrupt sequencer.
// Assumes csis_map.svh carries every numeric constant.
package csis_pkg;

	// Stack pointer operations requested by execution
	typedef enum logic [2:0] {
		CSIS_SP_NONE = 3'h0,
		CSIS_SP_PUSH = 3'h1,
		CSIS_SP_POP  = 3'h2,
		CSIS_SP_CALL = 3'h3,
		CSIS_SP_RET  = 3'h4
	} csis_spop_e;

	// Flag register update kinds from the ALU
	typedef enum logic [1:0] {
		CSIS_FL_NONE  = 2'h0,
		CSIS_FL_LOGIC = 2'h1,
		CSIS_FL_ARITH = 2'h2
	} csis_flop_e;

	// Interrupt sequencer states
	typedef enum logic [3:0] {
		CSIS_ST_RUN   = 4'h1,
		CSIS_ST_WAKE  = 4'h2,
		CSIS_ST_ENTRY = 4'h4,
		CSIS_ST_RETURN_FROM_INTERRUPT  = 4'h8
	} csis_state_e;

	typedef logic [15:0] csis_addr_t;

endpackage

// [src/csis_regfile.sv]
// Register file of 32 bytes with two read ports and a byte or word write.
// Assumes one clock and synchronous, reset-free storage; reads come from registers.
`timescale 1ns/1ps
`default_nettype none

module csis_regfile #(
	parameter int NREG = 32
) (
	input  wire logic       clock,
	input  wire logic       clk_en,
	input  wire logic [4:0] rd_a_addr,
	input  wire logic [4:0] rd_b_addr,
	input  wire logic       rd_wide,
	output logic      [15:0] rd_a_data,
	output logic      [7:0]  rd_b_data,
	input  wire logic       wr_en,
	input  wire logic       wr_wide,
	input  wire logic [4:0] wr_addr,
	input  wire logic [15:0] wr_data
);

	initial begin
		if (NREG != 32) $error("csis_regfile supports 32 registers only");
	end

	logic [7:0] mem_q [NREG];

	// Word writes land on an even pair, low byte in the lower register
	always_ff @(posedge clock) begin
		if (clk_en && wr_en) begin
			if (wr_wide) begin
				mem_q[{wr_addr[4:1], 1'b0}] <= wr_data[7:0];
				mem_q[{wr_addr[4:1], 1'b1}] <= wr_data[15:8];
			end else begin
				mem_q[wr_addr] <= wr_data[7:0];
			end
		end
	end

	// Registered reads; a wide read returns the even pair
	always_ff @(posedge clock) begin
		if (clk_en) begin
			if (rd_wide) begin
				rd_a_data <= {mem_q[{rd_a_addr[4:1], 1'b1}], mem_q[{rd_a_addr[4:1], 1'b0}]};
			end else begin
				rd_a_data <= {8'h00, mem_q[rd_a_addr]};
			end
			rd_b_data <= mem_q[rd_b_addr];
		end
	end

endmodule

`default_nettype wire

// [verif/csis_core_properties.sv]
// Checker of the core sequencer, bound to csis_core.
// Assumes one clock; all properties are disabled while rstn is low.
`timescale 1ns/1ps
`default_nettype none
module csis_core_properties
	import csis_pkg::*;
#(
	parameter int NSRC = 8
) (
	input wire logic                 clock,
	input wire logic                 rstn,
	input wire logic                 clk_en,
	input wire logic                 io_wr,
	input wire logic                 instr_cli,
	input wire logic                 instr_return_from_interrupt,
	input wire logic                 asleep,
	input wire csis_pkg::csis_spop_e sp_op,
	input wire logic [NSRC-1:0]      irq_enable,
	input wire logic [7:0]           core_flags_q,
	input wire logic [15:0]          sp_q,
	input wire logic [NSRC-1:0]      irq_pending_q,
	input wire logic                 irq_take_q,
	input wire logic                 seq_busy_q
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// Sign is derived, never stored on its own
	property p_sign;
		core_flags_q[4] == (core_flags_q[2] ^ core_flags_q[3]);
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag differs");
	property p_push;
		sp_op == CSIS_SP_PUSH && clk_en && !io_wr |=> sp_q == $past(sp_q) - 16'h1;
	endproperty
	a_push: assert property (p_push) else $error("push step wrong");
	property p_call;
		sp_op == CSIS_SP_CALL && clk_en && !io_wr |=> sp_q == $past(sp_q) - 16'h2;
	endproperty
	a_call: assert property (p_call) else $error("call step wrong");
	property p_ret;
		sp_op == CSIS_SP_RET && clk_en && !io_wr |=> sp_q == $past(sp_q) + 16'h2;
	endproperty
	a_ret: assert property (p_ret) else $error("return step wrong");
	// Clear-enable in the same cycle as a request still wins
	property p_cli;
		instr_cli && clk_en |=> !irq_take_q;
	endproperty
	a_cli: assert property (p_cli) else $error("take after clear");
	property p_gate;
		irq_take_q |-> $past(core_flags_q[7]) && $past(|(irq_pending_q & irq_enable));
	endproperty
	a_gate: assert property (p_gate) else $error("take not enabled");
	property p_entry;
		irq_take_q |=> sp_q == $past(sp_q) - 16'h2 && !core_flags_q[7];
	endproperty
	a_entry: assert property (p_entry) else $error("entry state wrong");
	property p_busy;
		irq_take_q && !asleep |-> seq_busy_q [*4] ##1 !seq_busy_q;
	endproperty
	a_busy: assert property (p_busy) else $error("entry length wrong");
	property p_return_from_interrupt;
		instr_return_from_interrupt && clk_en |=> ##1 sp_q == $past(sp_q, 2) + 16'h2 ##[0:4] core_flags_q[7];
	endproperty
	a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return wrong");
endmodule
bind csis_core csis_core_properties #(.NSRC(NSRC)) u_chk (.clock(clock), .rstn(rstn), .clk_en(clk_en),
	.io_wr(io_wr), .instr_cli(instr_cli), .instr_return_from_interrupt(instr_return_from_interrupt), .asleep(asleep), .sp_op(sp_op),
	.irq_enable(irq_enable), .core_flags_q(core_flags_q), .sp_q(sp_q), .irq_pending_q(irq_pending_q),
	.irq_take_q(irq_take_q), .seq_busy_q(seq_busy_q));
`default_nettype wire

// [verif/csis_src_model.sv]
// Partner model: peripheral interrupt sources that raise edge-type events.
// Assumes the core clock; the bench asks for events through fire.
`timescale 1ns/1ps
`default_nettype none
module csis_src_model #(
	parameter int NSRC = 8
) (
	input  wire logic            clock,
	input  wire logic [NSRC-1:0] fire,
	output logic      [NSRC-1:0] irq_event = '0
);
	// Edge sources follow fire one cycle late, so the line drops one cycle after fire drops
	always_ff @(posedge clock) begin
		irq_event <= fire;
	end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench of csis_core with an interrupt source model.
// Assumes a 50 ns clock and no sleep; vector select off until the last scenario.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import csis_pkg::*;
	logic        clock = 0, rstn = 0, io_wr = 0, io_rd = 0, rf_rd_wide = 0, rf_wr = 0, rf_wr_wide = 0;
	logic        fl_c = 0, fl_h = 0, fl_v = 0, instr_done = 0, instr_sei = 0, instr_cli = 0, instr_return_from_interrupt = 0;
	logic        fl_t_wr = 0, fl_t = 0, boot_fuse = 0;
	logic [5:0]  io_addr = '0;
	logic [7:0]  io_wdata = '0, fl_res = '0, irq_enable = '0, irq_flag_clr = '0, fire = '0;
	logic [4:0]  rf_a_addr = '0, rf_b_addr = '0, rf_wr_addr = '0;
	logic [15:0] rf_wr_data = '0;
	csis_flop_e  fl_op = CSIS_FL_NONE;
	csis_spop_e  sp_op = CSIS_SP_NONE;
	wire [7:0]   io_rdata_q, rf_b_data_q, core_flags_q, irq_pending_q, irq_event;
	wire [15:0]  rf_a_data_q, sp_q, vector_q, reset_vector_q;
	wire         irq_take_q, seq_busy_q;
	int          failures = 0, checks_done = 0;
	// Clock, 50 ns period
	always #25 clock = ~clock;
	csis_src_model #(.NSRC(8)) u_src (.clock(clock), .fire(fire), .irq_event(irq_event));
	csis_core #(.NSRC(8)) dut (.clock(clock), .rstn(rstn), .clk_en(1'b1), .io_wr(io_wr), .io_rd(io_rd),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .rf_a_addr(rf_a_addr),
		.rf_b_addr(rf_b_addr), .rf_rd_wide(rf_rd_wide), .rf_a_data_q(rf_a_data_q), .rf_b_data_q(rf_b_data_q),
		.rf_wr(rf_wr), .rf_wr_wide(rf_wr_wide), .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data),
		.fl_op(fl_op), .fl_c(fl_c), .fl_h(fl_h), .fl_v(fl_v), .fl_res(fl_res), .fl_t_wr(fl_t_wr), .fl_t(fl_t),
		.instr_done(instr_done), .instr_sei(instr_sei), .instr_cli(instr_cli), .instr_return_from_interrupt(instr_return_from_interrupt),
		.asleep(1'b0), .sp_op(sp_op), .irq_event(irq_event), .irq_enable(irq_enable),
		.irq_flag_clr(irq_flag_clr), .boot_reset_fuse(boot_fuse), .core_flags_q(core_flags_q), .sp_q(sp_q),
		.irq_pending_q(irq_pending_q), .irq_take_q(irq_take_q), .seq_busy_q(seq_busy_q), .vector_q(vector_q),
		.reset_vector_q(reset_vector_q));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH time=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic io_w(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		io_wr <= 1;
		io_addr <= a;
		io_wdata <= d;
		@(posedge clock);
		io_wr <= 0;
	endtask
	task automatic io_r(input logic [5:0] a, input logic [7:0] e);
		@(posedge clock);
		io_rd <= 1;
		io_addr <= a;
		@(posedge clock);
		io_rd <= 0;
		#1 chk(io_rdata_q, e);
	endtask
	task automatic sp_do(input csis_spop_e op, input logic [15:0] e);
		@(posedge clock);
		sp_op <= op;
		@(posedge clock);
		sp_op <= CSIS_SP_NONE;
		#1 chk(sp_q, e);
	endtask
	// One instruction event: k is {set, clear, return, done}; then the take strobe is judged
	task automatic instr(input logic [3:0] k, input logic e);
		@(posedge clock);
		{instr_sei, instr_cli, instr_return_from_interrupt, instr_done} <= k;
		@(posedge clock);
		{instr_sei, instr_cli, instr_return_from_interrupt, instr_done} <= 4'h0;
		#1 chk(irq_take_q, e);
	endtask
	task automatic t_stack();
		chk(core_flags_q, 8'h00);
		chk(sp_q, 16'h04ff);
		chk(reset_vector_q, 16'h0000);
		io_r(6'h3e, 8'h04);
		io_r(6'h3d, 8'hff);
		io_w(6'h3e, 8'h02);
		io_w(6'h3d, 8'h00);
		#1 chk(sp_q, 16'h0200);
		sp_do(CSIS_SP_PUSH, 16'h01ff);
		sp_do(CSIS_SP_POP, 16'h0200);
		sp_do(CSIS_SP_CALL, 16'h01fe);
		sp_do(CSIS_SP_RET, 16'h0200);
	endtask
	task automatic t_flags_regs();
		@(posedge clock);
		fl_op <= CSIS_FL_ARITH;
		{fl_res, fl_c, fl_h, fl_v} <= {8'h80, 3'b111};
		{fl_t_wr, fl_t} <= 2'b11;
		rf_wr <= 1;
		rf_wr_wide <= 1;
		rf_wr_addr <= 5'h1a;
		rf_wr_data <= 16'hbeef;
		@(posedge clock);
		fl_op <= CSIS_FL_NONE;
		{fl_t_wr, fl_t} <= 2'b00;
		{rf_wr, rf_a_addr, rf_b_addr, rf_rd_wide} <= {1'b0, 5'h1a, 5'h1b, 1'b1};
		#1 chk(core_flags_q, 8'h6d);
		repeat (3) @(posedge clock);
		#1 chk(rf_a_data_q, 16'hbeef);
		chk(rf_b_data_q, 8'hbe);
	endtask
	task automatic t_irq();
		@(posedge clock);
		irq_enable <= 8'h24;
		fire <= 8'h24;
		@(posedge clock);
		fire <= 8'h00;
		@(posedge clock);
		#1 chk(irq_pending_q, 8'h24);
		instr(4'h1, 1'b0);
		instr(4'h8, 1'b0);
		instr(4'h1, 1'b0);
		instr(4'h1, 1'b1);
		chk(vector_q, 16'h0006);
		@(posedge clock);
		#1 chk(sp_q, 16'h01fe);
		chk(core_flags_q[7], 1'b0);
		chk(seq_busy_q, 1'b1);
		repeat (2) @(posedge clock);
		#1 chk(seq_busy_q, 1'b1);
		@(posedge clock);
		#1 chk(seq_busy_q, 1'b0);
		@(posedge clock);
		#1 chk(irq_pending_q, 8'h20);
		instr(4'h2, 1'b0);
		@(posedge clock);
		#1 chk(sp_q, 16'h0200);
		repeat (4) @(posedge clock);
		#1 chk(core_flags_q[7], 1'b1);
		instr(4'h1, 1'b0);
		instr(4'h1, 1'b1);
		chk(vector_q, 16'h000c);
		repeat (5) @(posedge clock);
	endtask
	task automatic t_boot_cli();
		io_w(6'h35, 8'h02);
		@(posedge clock);
		fire <= 8'h81;
		irq_enable <= 8'h01;
		boot_fuse <= 1'b1;
		@(posedge clock);
		fire <= 8'h00;
		repeat (2) @(posedge clock);
		irq_flag_clr <= 8'h80;
		@(posedge clock);
		irq_flag_clr <= 8'h00;
		#1 chk(irq_pending_q, 8'h01);
		instr(4'h8, 1'b0);
		instr(4'h1, 1'b0);
		instr(4'h5, 1'b0);
		instr(4'h8, 1'b0);
		instr(4'h1, 1'b0);
		instr(4'h1, 1'b1);
		chk(vector_q, 16'h0c02);
		chk(reset_vector_q, 16'h0c00);
	endtask
	// Hang guard: a run this long means a sequence stalled
	initial begin
		repeat (3000) @(posedge clock);
		failures++;
		give_verdict();
	end
	initial begin
		repeat (6) @(posedge clock);
		rstn <= 1;
		repeat (3) @(posedge clock);
		#1 t_stack();
		t_flags_regs();
		t_irq();
		t_boot_cli();
		give_verdict();
	end
endmodule
`default_nettype wire
